// ### common/synth_regs_consts.svh
// Purpose: Constants for the synthesizer control-register block
// Assumes: 32-bit serial words, address in bits 3:0
// Notes: Field positions are bit indices within a word
`ifndef SYNTH_REGS_CONSTS_SVH
`define SYNTH_REGS_CONSTS_SVH
`define ADDR_MAIN 4'h0
`define ADDR_PHASE 4'h3
`define ADDR_REFPUMP 4'h4
`define ADDR_FIXED 4'h5
`define ADDR_OUTBLEED 4'h6
`define WORD_BITS 32
`define PH_RESYNC_BIT 29
`define PH_ADJUST_BIT 28
`define PH_VALUE_LSB 4
`define RP_MON_LSB 27
`define RP_DOUBLER_BIT 26
`define RP_HALVER_BIT 25
`define RP_RCOUNT_LSB 15
`define RP_DBUF_BIT 14
`define RP_PUMP_LSB 10
`define RP_REFMODE_BIT 9
`define RP_LEVEL_BIT 8
`define RP_POLARITY_BIT 7
`define RP_PWRDN_BIT 6
`define RP_TRISTATE_BIT 5
`define RP_CNTRST_BIT 4
`define OB_GATED_BIT 30
`define OB_NEGBLEED_BIT 29
`define OB_FBSEL_BIT 24
`define OB_DIVSEL_LSB 21
`define OB_BLEED_LSB 13
`define OB_MUTE_BIT 11
`define OB_BDIS_BIT 10
`define RESET_RCOUNT 10'h001
`endif

// ### common/synth_regs_pkg.sv
// Purpose: Types for the synthesizer control-register block
// Assumes: Constants come from synth_regs_consts.svh
// Notes: One packed struct holds the register state plus load-edge and reference synchronisers; serial pin synchronisers sit outside it
package synth_regs_pkg;
   typedef struct packed {
      logic [2:0] le_sync;
      logic [1:0] ref_sync;
      logic pending;
      logic [31:0] shift;
      logic resync_enable;
      logic phase_adjust_enable;
      logic [23:0] phase_value;
      logic [23:0] phase_acc;
      logic [2:0] monitor_output_select;
      logic reference_doubler_enable;
      logic reference_halver_enable;
      logic [9:0] ref_count;
      logic divider_double_buffer_enable;
      logic [3:0] pump_current_field;
      logic ref_differential;
      logic monitor_level_select;
      logic detector_polarity;
      logic soft_power_down;
      logic pump_tristate;
      logic counter_reset;
      logic gated_bleed_enable;
      logic negative_bleed_enable;
      logic feedback_source_select;
      logic [2:0] divsel_staged;
      logic [2:0] output_divider_select;
      logic [7:0] bleed_current_level;
      logic mute_until_lock;
      logic high_freq_output_disable;
      logic main_write;
   } state_t;
endpackage

// ### tb/host_serial_model.sv
// Purpose: Host side of the 3-wire serial write
// Assumes: Three clk per serial clock phase
// Notes: Serial clock idles low, data inverts when released
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] word,
   output logic sck,
   output logic sdi,
   output logic le,
   output logic busy
);
   initial {sck, sdi, le, busy} = 4'h0;
   // Shift MSB first so the address nibble lands last, then strobe
   always @(posedge clk)
   begin
      if (go)
      begin
         busy <= 1'b1;
         for (int i = 31; i >= 0; i--)
         begin
            sdi <= word[i];
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
            sck <= 1'b0;
         end
         sdi <= ~word[0];
         le <= 1'b1;
         repeat (3) @(posedge clk);
         le <= 1'b0;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/synth_phase_ref_output_regs_test.sv
// Purpose: Self-checking bench for the control-register block
// Assumes: Host model delivers whole words
// Notes: Each write waits for the commit latency
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s exp %0h got %0h", n, e, g); end end
module synth_phase_ref_output_regs_test;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic go = 1'b0;
   logic [31:0] word = 32'h0;
   logic ref_rise = 1'b0;
   logic sync_en = 1'b0;
   logic lock = 1'b0;
   logic busy, sck, sdi, le, rs, pa, mw, lvl, dbl, hlv, dif, pol, pe, cr, opd, ldr, be, nb, fb, oa, ob;
   logic [23:0] ph;
   logic [2:0] mon, div;
   logic [9:0] rdv;
   logic [3:0] cp;
   logic [7:0] bl;
   int n_fail = 0;
   int n_tests = 0;
   int n_mw = 0;
   always #25 clk = ~clk;
   // Count main-write pulses seen on the design output
   always @(posedge clk)
   begin
      if (mw === 1'b1)
         n_mw <= n_mw + 1;
   end
   host_serial_model host_serial_model_inst (.clk(clk), .go(go), .word(word), .sck(sck),
      .sdi(sdi), .le(le), .busy(busy));
   synth_phase_ref_output_regs #(.RCOUNT_W(10)) synth_phase_ref_output_regs_inst (
      .clk(clk), .arst_n(arst_n), .serial_clock(sck), .serial_data(sdi), .load_strobe(le),
      .ref_in_rise(ref_rise), .load_sync_enable(sync_en), .lock_detect(lock),
      .resync_enable(rs), .phase_adjust_enable(pa), .phase_offset(ph), .main_write(mw),
      .monitor_output_select(mon), .monitor_level_select(lvl), .reference_doubler_enable(dbl),
      .reference_halver_enable(hlv), .ref_divide(rdv), .pump_current_field(cp),
      .ref_differential(dif), .detector_polarity(pol), .pump_enable(pe), .counters_reset(cr),
      .oscillator_power_down(opd), .lock_detect_reset(ldr), .bleed_enable(be),
      .negative_bleed_enable(nb), .feedback_source_select(fb), .output_divider_select(div),
      .bleed_current_level(bl), .output_a_power(oa), .output_b_power(ob));
   // Reference word with power-down, tristate, reset flags and double buffer
   function automatic logic [31:0] refw(input logic [2:0] u, input logic d);
      return {2'b00, 3'h5, 2'b11, 10'h3FF, d, 4'h9, 3'b111, u, 4'h4};
   endfunction
   // Output word keeping the fixed bit values
   function automatic logic [31:0] outw(input logic [2:0] d);
      return {4'b0111, 3'b010, 1'b1, d, 8'hA5, 3'b011, 6'h00, 4'h6};
   endfunction
   task automatic wr(input logic [31:0] w);
      word <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 400 && busy; i++) @(posedge clk);
      `CHK("busy", 1'b0, busy)
      repeat (10) @(posedge clk);
   endtask
   task automatic t_ref();
      `CHK("rdv_rst", 10'h001, rdv)
      wr(refw(3'b000, 1'b0));
      `CHK("mon", 3'h5, mon)
      `CHK("dbl", 1'b1, dbl)
      `CHK("hlv", 1'b1, hlv)
      `CHK("rdv", 10'h3FF, rdv)
      `CHK("cp", 4'h9, cp)
      `CHK("dif", 1'b1, dif)
      `CHK("pol", 1'b1, pol)
      wr(refw(3'b100, 1'b0));
      `CHK("pd", 5'h10, {opd, pe, oa, ob, lvl ^ 1'b1})
      `CHK("pd_rst", 2'h3, {ldr, cr})
      wr(refw(3'b010, 1'b0));
      `CHK("tri", 2'h0, {opd, pe})
      wr(refw(3'b001, 1'b0));
      `CHK("cnt_rst", 2'h3, {cr, pe})
   endtask
   task automatic t_out();
      wr(outw(3'h3));
      `CHK("gated", 3'h0, {be, oa, ob})
      `CHK("fields", 14'h374B, {nb, fb, div, bl, 1'b1})
      lock <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("locked", 2'h3, {be, oa})
      lock <= 1'b0;
      wr(refw(3'b000, 1'b1));
      wr(outw(3'h5));
      `CHK("div_held", 3'h3, div)
      wr(32'h0);
      `CHK("div_new", 3'h5, div)
      `CHK("mw_one", 1, n_mw)
      `CHK("mw_idle", 1'b0, mw)
   endtask
   task automatic t_phase();
      wr({4'b0001, 24'hC00000, 4'h3});
      `CHK("pa", 2'h1, {rs, pa})
      wr(32'h0);
      `CHK("ph1", 24'hC00000, ph)
      wr(32'h0);
      `CHK("ph2", 24'h800000, ph)
      wr({4'b0010, 24'h0, 4'h3});
      `CHK("rs", 2'h2, {rs, pa})
      wr(32'h0);
      `CHK("ph3", 24'h800000, ph)
      `CHK("mw_four", 4, n_mw)
      wr(32'h00800005);
      wr(32'hFFFFFFF7);
      `CHK("ignored", 11'h5A5, {mon, bl})
   endtask
   task automatic t_sync();
      sync_en <= 1'b1;
      wr(refw(3'b000, 1'b0) ^ 32'h02000000);
      `CHK("sync_wait", 1'b1, hlv)
      ref_rise <= 1'b1;
      @(posedge clk);
      ref_rise <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("sync_done", 1'b0, hlv)
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      `CHK("rst_out", 4'hF, {pe, be, oa, ob})
      t_ref();
      t_out();
      t_phase();
      t_sync();
      print_verdict();
   end
endmodule
`default_nettype wire

// ### tb/synth_regs_checker.sv
// Purpose: Port assertions for the control-register block
// Assumes: Bound to the block top, one clock domain
// Notes: Output relations only, no register internals
`timescale 1ns/1ps
`default_nettype none
module synth_regs_checker #(
   parameter int RCOUNT_W = 10
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic lock_detect,
   input wire logic main_write,
   input wire logic phase_adjust_enable,
   input wire logic [23:0] phase_offset,
   input wire logic [RCOUNT_W-1:0] ref_divide,
   input wire logic pump_enable,
   input wire logic counters_reset,
   input wire logic oscillator_power_down,
   input wire logic bleed_enable,
   input wire logic output_a_power,
   input wire logic output_b_power
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Power down silences outputs and pump
   pd_outputs_a:
      assert property (oscillator_power_down |-> !output_a_power && !output_b_power && !pump_enable)
         else $error("Output or pump on in power down");
   pd_reset_a:
      assert property (oscillator_power_down |-> counters_reset)
         else $error("Counters not held in power down");
   // Lock releases gated bleed and muted output
   bleed_lock_a:
      assert property (lock_detect |-> bleed_enable) else $error("Bleed off while locked");
   mute_lock_a:
      assert property (lock_detect && !oscillator_power_down |-> output_a_power)
         else $error("Output A off while locked");
   // Main write is a single pulse
   main_pulse_a:
      assert property (main_write |=> !main_write) else $error("Main write longer than one cycle");
   phase_step_a:
      assert property ($changed(phase_offset) |-> main_write || $past(main_write))
         else $error("Phase moved without main write");
   adjust_gate_a:
      assert property ($changed(phase_offset) |-> phase_adjust_enable)
         else $error("Phase moved with adjust off");
   divide_range_a:
      assert property (ref_divide != '0) else $error("Reference divide of zero");
   cover property (main_write);
   cover property (oscillator_power_down);
   cover property (!bleed_enable);
endmodule
bind synth_phase_ref_output_regs synth_regs_checker #(.RCOUNT_W(RCOUNT_W)) synth_regs_checker_inst (
   .clk(clk), .arst_n(arst_n), .lock_detect(lock_detect), .main_write(main_write),
   .phase_adjust_enable(phase_adjust_enable), .phase_offset(phase_offset),
   .ref_divide(ref_divide), .pump_enable(pump_enable), .counters_reset(counters_reset),
   .oscillator_power_down(oscillator_power_down), .bleed_enable(bleed_enable),
   .output_a_power(output_a_power), .output_b_power(output_b_power));
`default_nettype wire

// ### verilog/synth_phase_ref_output_regs.sv
// Purpose: Serial control registers for phase, reference path and output controls
// Assumes: Serial pins and load strobe are asynchronous to clk
// Notes: Words shift MSB first; a strobe rising edge commits the word
// Operation
// - Phase word bit 29 enables phase resynchronisation.
// - Phase word bit 28 enables phase shift on each main write.
// - Each main write advances phase by stored 24-bit phase value.
// - Low four address bits route word; 0100 reference, 0110 output.
// - Reference bits 29:27 choose the monitor output signal.
// - Bit 26 enables reference doubler, both edges active.
// - Bit 25 inserts divide-by-two stage after R counter.
// - Ten-bit reference counter divides by 1 through 1023.
// - Bit 14 holds new divider select until main write.
// - Bits 13:10 set charge pump current.
// - Bit 9 selects differential or single-ended reference.
// - Bit 7 sets phase detector polarity.
// - Bit 6 power-down forces counters, pump, lock, outputs off.
// - Bit 5 tristates the charge pump.
// - Bit 4 holds R, N counters and band select reset.
// - Output bit 30 keeps bleed off until lock detected.
// - Bit 24 selects fundamental or divided feedback.
// - Bit 11 keeps output A stage off until lock.
// - Bit 10 disables high-frequency output when set.
// - Load edge aligned to reference rising edge when sync enabled.
`timescale 1ns/1ps
`default_nettype none
`include "synth_regs_consts.svh"
module synth_phase_ref_output_regs #(
   parameter int RCOUNT_W = 10
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic ref_in_rise,
   input wire logic load_sync_enable,
   input wire logic lock_detect,
   output logic resync_enable,
   output logic phase_adjust_enable,
   output logic [23:0] phase_offset,
   output logic main_write,
   output logic [2:0] monitor_output_select,
   output logic monitor_level_select,
   output logic reference_doubler_enable,
   output logic reference_halver_enable,
   output logic [RCOUNT_W-1:0] ref_divide,
   output logic [3:0] pump_current_field,
   output logic ref_differential,
   output logic detector_polarity,
   output logic pump_enable,
   output logic counters_reset,
   output logic oscillator_power_down,
   output logic lock_detect_reset,
   output logic bleed_enable,
   output logic negative_bleed_enable,
   output logic feedback_source_select,
   output logic [2:0] output_divider_select,
   output logic [7:0] bleed_current_level,
   output logic output_a_power,
   output logic output_b_power
);
   synth_regs_pkg::state_t st;
   synth_regs_pkg::state_t next_st;
   logic [1:0] sclk_sync;
   logic [1:0] sdat_sync;
   logic [1:0] le_pin_sync;
   logic sclk_prev;

   // Two-stage synchronisers for pins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_sync <= 2'h0;
         sdat_sync <= 2'h0;
         le_pin_sync <= 2'h0;
         sclk_prev <= 1'h0;
      end
      else
      begin
         sclk_sync <= {sclk_sync[0], serial_clock};
         sdat_sync <= {sdat_sync[0], serial_data};
         le_pin_sync <= {le_pin_sync[0], load_strobe};
         sclk_prev <= sclk_sync[1];
      end
   end

   // Next-state logic: shift, commit, phase accumulation
   always_comb
   begin
      logic [31:0] w;
      logic commit;
      w = st.shift;
      commit = 1'h0;
      next_st = st;
      next_st.main_write = 1'h0;
      next_st.le_sync = {st.le_sync[1:0], le_pin_sync[1]};
      next_st.ref_sync = {st.ref_sync[0], ref_in_rise};
      if (sclk_sync[1] && !sclk_prev)
      begin
         next_st.shift = {st.shift[30:0], sdat_sync[1]};
      end
      // Rising load edge arms the commit
      if (st.le_sync[1] && !st.le_sync[2])
      begin
         next_st.pending = 1'h1;
      end
      // Align commit to reference rising edge when requested
      if (st.pending)
      begin
         commit = !load_sync_enable || st.ref_sync[1];
      end
      if (commit)
      begin
         next_st.pending = 1'h0;
         unique case (w[3:0])
            `ADDR_MAIN:
            begin
               next_st.main_write = 1'h1;
               if (st.phase_adjust_enable)
               begin
                  // Carry out of bit 23 is dropped on purpose: one full turn
                  next_st.phase_acc = 24'(st.phase_acc + st.phase_value);
               end
               next_st.output_divider_select = st.divsel_staged;
            end
            `ADDR_PHASE:
            begin
               next_st.resync_enable = w[`PH_RESYNC_BIT];
               next_st.phase_adjust_enable = w[`PH_ADJUST_BIT];
               next_st.phase_value = w[`PH_VALUE_LSB +: 24];
            end
            `ADDR_REFPUMP:
            begin
               next_st.monitor_output_select = w[`RP_MON_LSB +: 3];
               next_st.reference_doubler_enable = w[`RP_DOUBLER_BIT];
               next_st.reference_halver_enable = w[`RP_HALVER_BIT];
               next_st.ref_count = w[`RP_RCOUNT_LSB +: 10];
               next_st.divider_double_buffer_enable = w[`RP_DBUF_BIT];
               next_st.pump_current_field = w[`RP_PUMP_LSB +: 4];
               next_st.ref_differential = w[`RP_REFMODE_BIT];
               next_st.monitor_level_select = w[`RP_LEVEL_BIT];
               next_st.detector_polarity = w[`RP_POLARITY_BIT];
               next_st.soft_power_down = w[`RP_PWRDN_BIT];
               next_st.pump_tristate = w[`RP_TRISTATE_BIT];
               next_st.counter_reset = w[`RP_CNTRST_BIT];
            end
            `ADDR_OUTBLEED:
            begin
               next_st.gated_bleed_enable = w[`OB_GATED_BIT];
               next_st.negative_bleed_enable = w[`OB_NEGBLEED_BIT];
               next_st.feedback_source_select = w[`OB_FBSEL_BIT];
               next_st.divsel_staged = w[`OB_DIVSEL_LSB +: 3];
               if (!st.divider_double_buffer_enable)
               begin
                  next_st.output_divider_select = w[`OB_DIVSEL_LSB +: 3];
               end
               next_st.bleed_current_level = w[`OB_BLEED_LSB +: 8];
               next_st.mute_until_lock = w[`OB_MUTE_BIT];
               next_st.high_freq_output_disable = w[`OB_BDIS_BIT];
            end
            default:
            begin
               next_st.pending = 1'h0; // Other addresses belong to other blocks
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
         st.ref_count <= `RESET_RCOUNT;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Register-driven phase and main-write outputs, not gated
   assign resync_enable = st.resync_enable;
   assign phase_adjust_enable = st.phase_adjust_enable;
   assign phase_offset = st.phase_acc;
   assign main_write = st.main_write;

   // Monitor and reference path fields
   assign monitor_output_select = st.monitor_output_select;
   assign monitor_level_select = st.monitor_level_select;
   assign reference_doubler_enable = st.reference_doubler_enable;
   assign reference_halver_enable = st.reference_halver_enable;
   assign ref_divide = RCOUNT_W'(st.ref_count);
   assign pump_current_field = st.pump_current_field;
   assign ref_differential = st.ref_differential;
   assign detector_polarity = st.detector_polarity;

   // Pump, counters, oscillator and lock detect follow power-down
   assign pump_enable = !st.pump_tristate && !st.soft_power_down;
   assign counters_reset = st.counter_reset || st.soft_power_down;
   assign oscillator_power_down = st.soft_power_down;
   assign lock_detect_reset = st.soft_power_down;

   // Bleed and feedback controls; gated bleed waits for lock
   assign bleed_enable = !st.gated_bleed_enable || lock_detect;
   assign negative_bleed_enable = st.negative_bleed_enable;
   assign feedback_source_select = st.feedback_source_select;
   assign output_divider_select = st.output_divider_select;
   assign bleed_current_level = st.bleed_current_level;

   // Output stages, off in power-down, muted output waits for lock
   assign output_a_power = !st.soft_power_down && (!st.mute_until_lock || lock_detect);
   assign output_b_power = !st.soft_power_down && !st.high_freq_output_disable;
endmodule
`default_nettype wire
